// >>> verilog/flash_wr_consts.svh
// timing counts and delays for the flash write host controller
// assumes a 200 MHz clock on the including module
// Summary of operation
// - never oe and strobe low together
// - back-to-back access needs address change; the host drops select between writes instead, so none is needed
// - no access for 300 us after power-up
// - hardware reset recovers a locked device
`ifndef FLASH_WR_CONSTS_SVH
`define FLASH_WR_CONSTS_SVH
`define CLK_PERIOD_PS 5000
`define POWER_ON_DELAY_US 300
`define POWER_ON_DELAY_CYC ((`POWER_ON_DELAY_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GLITCH_NS 5
`define STROBE_LOW_CYC 4
`define SETUP_CYC 2
`define HOLD_CYC 2
`define RESET_PULSE_CYC 8
`endif

// >>> verilog/flash_wr_pkg.sv
// types for the flash write host controller
// assumes nothing beyond the consts header
package flash_wr_pkg;
    typedef enum logic [2:0] {
        st_power_on = 3'b000,
        st_idle = 3'b001,
        st_setup = 3'b011,
        st_strobe = 3'b010,
        st_hold = 3'b110,
        st_reset = 3'b111
    } wr_state_t;
    typedef enum logic {
        mode_strobe = 1'b0,
        mode_select = 1'b1
    } wr_mode_t;
endpackage

// >>> verilog/flash_wr_host.sv
// host controller that issues asynchronous writes to a parallel flash
// assumes a single 200 MHz clock; flash pins leave and enter through this module
`include "flash_wr_consts.svh"
module flash_wr_host #(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16,
    parameter int POWER_ON_CYC = `POWER_ON_DELAY_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire flash_wr_pkg::wr_mode_t req_mode,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    input wire logic recover_req,
    output logic done,
    output logic powered_ok,
    input wire logic ready_busy_in,
    output logic busy,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic reset_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe
);
    import flash_wr_pkg::*;

    localparam int STROBE_CYC = `STROBE_LOW_CYC;
    localparam int GLITCH_CYC = (`GLITCH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;

    // refuse sizes the counters cannot serve; strobe must outlast the noise filter window
    if (ADDR_W < 1 || DATA_W < 1 || POWER_ON_CYC < 1 || STROBE_CYC <= GLITCH_CYC)
    begin
        $error("flash_wr_host: unsupported parameters");
    end

    wr_state_t state_ff;
    wr_mode_t mode_ff;
    logic [31:0] cnt_ff;
    logic rb_meta_ff;
    logic rb_sync_ff;

    // ready/busy pin crosses in through two flip-flops
    // busy reads high for two edges after reset, until the pin has been sampled
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rb_meta_ff <= 1'b0;
            rb_sync_ff <= 1'b0;
        end
        else
        begin
            rb_meta_ff <= ready_busy_in;
            rb_sync_ff <= rb_meta_ff;
        end
    end
    assign busy = !rb_sync_ff;

    // sequencer: power-on wait, then one write per request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= st_power_on;
            cnt_ff <= '0;
            mode_ff <= mode_strobe;
        end
        else
        begin
            unique case (state_ff)
                st_power_on:
                begin
                    if (cnt_ff == 32'(POWER_ON_CYC - 1))
                    begin
                        state_ff <= st_idle;
                        cnt_ff <= '0;
                    end
                    else
                        cnt_ff <= cnt_ff + 32'h1;
                end
                st_idle:
                begin
                    cnt_ff <= '0;
                    if (recover_req)
                        state_ff <= st_reset;
                    else if (req_valid)
                    begin
                        mode_ff <= req_mode;
                        state_ff <= st_setup;
                    end
                end
                st_setup:
                begin
                    if (cnt_ff == 32'(`SETUP_CYC - 1))
                    begin
                        state_ff <= st_strobe;
                        cnt_ff <= '0;
                    end
                    else
                        cnt_ff <= cnt_ff + 32'h1;
                end
                st_strobe:
                begin
                    if (cnt_ff == 32'(STROBE_CYC - 1))
                    begin
                        state_ff <= st_hold;
                        cnt_ff <= '0;
                    end
                    else
                        cnt_ff <= cnt_ff + 32'h1;
                end
                st_hold:
                begin
                    if (cnt_ff == 32'(`HOLD_CYC - 1))
                    begin
                        state_ff <= st_idle;
                        cnt_ff <= '0;
                    end
                    else
                        cnt_ff <= cnt_ff + 32'h1;
                end
                st_reset:
                begin
                    if (cnt_ff == 32'(`RESET_PULSE_CYC - 1))
                    begin
                        state_ff <= st_power_on; // wait the delay again
                        cnt_ff <= '0;
                    end
                    else
                        cnt_ff <= cnt_ff + 32'h1;
                end
                default:
                    state_ff <= st_power_on;
            endcase
        end
    end

    // address and data registers, loaded when a request is taken; they then stand
    // unchanged through setup, strobe and hold, so both latching edges see one word
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr <= '0;
            dq_out <= '0;
        end
        else if (state_ff == st_idle && req_valid && !recover_req)
        begin
            addr <= req_addr;
            dq_out <= req_data;
        end
    end

    // pin levels from state; select drops between writes so no address change needed
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            dq_oe <= 1'b0;
            reset_n <= 1'b1;
        end
        else
        begin
            oe_n <= 1'b1; // oe never low with strobe
            reset_n <= !(state_ff == st_reset && !(cnt_ff == 32'(`RESET_PULSE_CYC - 1)));
            unique case (state_ff)
                st_setup:
                begin
                    // strobe mode: select first select mode: strobe first
                    ce_n <= (mode_ff == mode_strobe) ? 1'b0 : (cnt_ff != 32'(`SETUP_CYC - 1));
                    we_n <= (mode_ff == mode_strobe) ? (cnt_ff != 32'(`SETUP_CYC - 1)) : 1'b0;
                    dq_oe <= 1'b1;
                end
                st_strobe:
                begin
                    ce_n <= 1'b0;
                    we_n <= 1'b0; // later falling edge latches address
                    dq_oe <= 1'b1;
                    if (cnt_ff == 32'(STROBE_CYC - 1))
                    begin
                        // earlier rising edge latches data
                        ce_n <= (mode_ff == mode_select);
                        we_n <= (mode_ff == mode_strobe);
                    end
                end
                st_hold:
                begin
                    ce_n <= 1'b1; // end in standby
                    we_n <= 1'b1;
                    dq_oe <= (cnt_ff != 32'(`HOLD_CYC - 1));
                end
                default:
                begin
                    ce_n <= 1'b1;
                    we_n <= 1'b1;
                    dq_oe <= 1'b0;
                end
            endcase
        end
    end

    // completion pulse after the write cycle closes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            done <= 1'b0;
        else
            done <= (state_ff == st_hold && cnt_ff == 32'(`HOLD_CYC - 1));
    end

    assign req_ready = (state_ff == st_idle) && !recover_req;
    assign powered_ok = (state_ff != st_power_on) && (state_ff != st_reset);
    // select always returns high between writes, so repeats need no address change
    // a host that kept select low would have to move the address before each new access
endmodule

// >>> sim/flash_wr_checker_sva.sv
// assertions on the pins of the flash write host
// assumes the flash_wr_host port list; bound at the foot
module flash_wr_checker
import flash_wr_pkg::*;
#(parameter int ADDR_W = 26, parameter int DATA_W = 16) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire flash_wr_pkg::wr_mode_t req_mode,
    input wire logic done,
    input wire logic powered_ok,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // strobe-controlled walk: select first, strobe inside it
    sequence s_strobe_ctl;
        !ce_n && we_n ##1 (!ce_n && !we_n) [*4] ##1 !ce_n && we_n ##1 ce_n && we_n;
    endsequence
    // select-controlled walk: strobe first, select inside it
    sequence s_select_ctl;
        ce_n && !we_n ##1 (!ce_n && !we_n) [*4] ##1 ce_n && !we_n ##1 ce_n && we_n;
    endsequence
    a_strobe_walk: assert property (req_valid && req_ready && req_mode == mode_strobe |-> ##2 s_strobe_ctl)
        else $error("strobe write walk broken");
    a_select_walk: assert property (req_valid && req_ready && req_mode == mode_select |-> ##2 s_select_ctl)
        else $error("select write walk broken");
    a_done_time: assert property (req_valid && req_ready |-> ##9 done)
        else $error("done late or missing");
    a_done_idle: assert property (done |-> ce_n && we_n && !dq_oe)
        else $error("pins busy at done");
    a_oe_high: assert property (oe_n)
        else $error("output enable driven low");
    a_no_glitch: assert property ($fell(we_n) |-> !we_n [*4])
        else $error("strobe pulse too short");
    a_drive_write: assert property (!ce_n && !we_n |-> dq_oe && oe_n)
        else $error("write without data drive");
    a_hold_word: assert property (!ce_n && !we_n |-> $stable(addr) && $stable(dq_out))
        else $error("word moved during write");
    a_quiet_power: assert property (!powered_ok |-> ce_n && we_n)
        else $error("access before power delay");
    a_reset_pulse: assert property ($fell(reset_n) |-> !reset_n [*7] ##1 reset_n)
        else $error("reset pulse width wrong");
endmodule
bind flash_wr_host flash_wr_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clk(clk),
    .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready), .req_mode(req_mode),
    .done(done), .powered_ok(powered_ok), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .reset_n(reset_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));

// >>> sim/flash_dev_model.sv
// behavioural flash write port driven by the host pins
// assumes pins sampled on the host clock; ready line driven high and low by the model
module flash_dev_model #(parameter int AW = 26, parameter int DW = 16) (
    input wire logic clk,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic reset_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] dq,
    output logic rb,
    output logic [AW-1:0] cap_addr,
    output logic [DW-1:0] cap_data,
    output int rst_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_ff = 1'b0;
    int busy_ff = 0;
    // capture words into cap_addr and cap_data, then report busy a while
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            rst_low++;
            wr_ff <= 1'b0;
            busy_ff <= 0;
        end
        else if (!ce_n && !we_n && oe_n && !wr_ff)
        begin
            wr_ff <= 1'b1;
            cap_addr <= addr;
        end
        else if (wr_ff && (ce_n || we_n))
        begin
            wr_ff <= 1'b0;
            cap_data <= dq;
            busy_ff <= 3;
        end
        else if (busy_ff > 0)
            busy_ff <= busy_ff - 1;
    end
    assign rb = (busy_ff == 0);
endmodule

// >>> sim/tb_flash_wr_host.sv
// self-checking bench for the flash write host
// assumes the device model and checker files compiled before it
`include "flash_wr_consts.svh"
module tb_flash_wr_host;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_wr_pkg::*;
    localparam int AW = 26;
    localparam int DW = 16;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    wr_mode_t req_mode = mode_strobe;
    logic [AW-1:0] req_addr = '0;
    logic [DW-1:0] req_data = '0;
    logic recover_req = 1'b0;
    logic req_ready, done, powered_ok, rb, busy, ce_n, we_n, oe_n, reset_n, dq_oe;
    logic [AW-1:0] addr, cap_addr;
    logic [DW-1:0] dq_out, cap_data, dq;
    int err_total = 0;
    int checked = 0;
    int rst_low;
    int rst_base;
    int n;
    // released data lines show the inverse of the last word
    assign dq = dq_oe ? dq_out : ~dq_out;
    always #2.5 clk = ~clk;
    flash_wr_host #(.ADDR_W(AW), .DATA_W(DW), .POWER_ON_CYC(20)) dut (.clk(clk), .arst_n(arst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_mode(req_mode), .req_addr(req_addr),
        .req_data(req_data), .recover_req(recover_req), .done(done), .powered_ok(powered_ok),
        .ready_busy_in(rb), .busy(busy), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .reset_n(reset_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));
    flash_dev_model #(.AW(AW), .DW(DW)) dev (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .reset_n(reset_n), .addr(addr), .dq(dq), .rb(rb), .cap_addr(cap_addr),
        .cap_data(cap_data), .rst_low(rst_low));
    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // cycles from the taking edge to done
    function automatic int done_lat();
        return 1 + `SETUP_CYC + `STROBE_LOW_CYC + `HOLD_CYC;
    endfunction
    // one write, checked against what the device captured
    task automatic write(input wr_mode_t m, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req_mode <= m;
        req_addr <= a;
        req_data <= d;
        #1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(req_ready, 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        // done is launched by the last edge before done_lat() edges have passed
        repeat (done_lat() - 1) @(posedge clk);
        #1;
        check(done, 1'b1);
        check(cap_addr, a);
        check(cap_data, d);
        // the device now reports busy, seen one edge later through the input sync
        @(posedge clk);
        #1;
        check(busy, 1'b1);
    endtask
    // wait for the power-on delay to end, bounded
    task automatic wait_power();
        n = 0;
        while (powered_ok !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n >= 20, 1'b1);
        check(powered_ok, 1'b1);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #20000;
        err_total++;
        test_done();
    end
    // main sequence
    initial
    begin
        void'($urandom(8832));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check(powered_ok, 1'b0);
        wait_power();
        write(mode_strobe, '0, '0);
        write(mode_select, '1, '1);
        repeat (10) write(wr_mode_t'($urandom % 2), AW'($urandom), DW'($urandom));
        $display("test writes finished");
        rst_base = rst_low;
        @(posedge clk);
        recover_req <= 1'b1;
        @(posedge clk);
        recover_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(powered_ok, 1'b0);
        wait_power();
        check(rst_low - rst_base, `RESET_PULSE_CYC - 1);
        write(mode_select, AW'($urandom), DW'($urandom));
        $display("test recover finished");
        test_done();
    end
endmodule
